// ### shared/trip_pkg.sv
// Constants and carrier types for the motor overload trip decision logic.
// Assumes a single 250 MHz clock and an AXI4-Lite register slave.
`default_nettype none
package trip_pkg;
    // ==========================================================
    // Clock and delay figures.
    // ==========================================================
    localparam longint unsigned CLK_HZ = 250_000_000;
    localparam longint unsigned AUTO_CLEAR_DELAY_MIN = 2;
    localparam longint unsigned PHASE_LOSS_DELAY_S = 4;
    localparam longint unsigned IMBALANCE_DELAY_S = 5;
    localparam longint unsigned GROUND_DELAY_S = 1;
    localparam longint unsigned AUTO_CLEAR_CYC = AUTO_CLEAR_DELAY_MIN * 60 * CLK_HZ;
    localparam longint unsigned PHASE_LOSS_CYC = PHASE_LOSS_DELAY_S * CLK_HZ;
    localparam longint unsigned IMBALANCE_CYC = IMBALANCE_DELAY_S * CLK_HZ;
    localparam longint unsigned GROUND_CYC = GROUND_DELAY_S * CLK_HZ;
    // ==========================================================
    // Thresholds, as ratios of integers.
    // ==========================================================
    localparam logic [3:0] LOSS_LOW_DEN = 4'hA;
    localparam logic [3:0] LOSS_HIGH_NUM = 4'h8;
    localparam logic [7:0] IMB_LIMIT_PCT = 8'h28;
    localparam logic [7:0] PCT_SCALE = 8'h64;
    localparam logic [7:0] THERMAL_LIMIT_PCT = 8'h64;
    localparam logic [9:0] GF_REF_NUM = 10'h04B;
    localparam logic [9:0] GF_REF_DEN = 10'h3E8;
    // ==========================================================
    // Trip cause bit positions.
    // ==========================================================
    localparam int CAUSE_THERMAL = 0;
    localparam int CAUSE_PHASE_LOSS = 1;
    localparam int CAUSE_IMBALANCE = 2;
    localparam int CAUSE_GROUND = 3;
    // ==========================================================
    // Register map, byte addresses, and field positions.
    // ==========================================================
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IMBALANCE = 8'h08;
    localparam logic [7:0] REG_SETTINGS = 8'h0C;
    localparam int CTRL_CLEAR_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Carrier types.
    // ==========================================================
    typedef struct packed {
        logic [15:0] phase1_current;
        logic [15:0] phase2_current;
        logic [15:0] phase3_current;
    } phase_currents_t;
    typedef struct packed {
        logic [15:0] rated_current_setting;
        logic manual_clear_setting;
        logic imbalance_protect_enable;
        logic ground_protect_enable;
        logic reset_request;
    } switch_set_t;
endpackage
`default_nettype wire

// ### logic/motor_trip.sv
// Trip decision logic of a three-phase motor overload relay.
// Assumes currents from a front end on the same clock; switches and the
// reset button are asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Manual reset clears thermal trip once capacity is at or below 100 percent.
// - Switch selects automatic thermal clearing.
// - Manual-only mode keeps thermal trip latched.
// - Automatic mode releases thermal trip after 2 minutes.
// - Phase loss: one below 0.1, another above 0.8.
// - Phase loss trips after 4 seconds.
// - Phase loss detection can never be disabled.
// - Phase loss trip clears manually only.
// - Average current and per-phase deviation percentages computed.
// - Network imbalance ratio is largest phase ratio.
// - Enabled imbalance above 40 percent trips after 5s.
// - Switch disables imbalance protection completely.
// - Imbalance trip clears manually only.
// - Switch enables ground fault; reference 0.75 rated.
// - Disabled ground protection never trips.
// - Ground current above 10 percent trips after 1s.
// - Ground-fault trip clears manually only.
// - Any trip latches, swapping both auxiliary contacts.
// - Trip request beats simultaneous reset request.
// - Thermal capacity above 100 percent trips.
module motor_trip
#(
    parameter logic [35:0] AUTO_CLEAR_CYC_P = trip_pkg::AUTO_CLEAR_CYC[35:0],
    parameter logic [35:0] PHASE_LOSS_CYC_P = trip_pkg::PHASE_LOSS_CYC[35:0],
    parameter logic [35:0] IMBALANCE_CYC_P = trip_pkg::IMBALANCE_CYC[35:0],
    parameter logic [35:0] GROUND_CYC_P = trip_pkg::GROUND_CYC[35:0]
)
(
    // Clock and reset.
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    // AXI4-Lite write channels.
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // AXI4-Lite read channels.
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // Measurements from the front end, same clock.
    input wire trip_pkg::phase_currents_t PHASE_CURRENTS_I,
    input wire logic [15:0] GROUND_CURRENT_I,
    input wire logic [7:0] THERMAL_CAPACITY_I,
    // Rotary switches and reset button, asynchronous pins.
    input wire trip_pkg::switch_set_t SWITCHES_I,
    // Auxiliary contacts and trip cause.
    output logic NC_CONTACT_CLOSED_O,
    output logic NO_CONTACT_CLOSED_O,
    output logic [3:0] TRIP_CAUSE_O
);
    import trip_pkg::*;

    // ==========================================================
    // State.
    // ==========================================================
    // All registers of the block; the first synchroniser stage is read
    // only by the second.
    typedef struct packed {
        switch_set_t sync_a;
        switch_set_t sync_b;
        logic trip;
        logic nc_closed;
        logic [3:0] cause;
        logic [35:0] cnt_loss;
        logic [35:0] cnt_imb;
        logic [35:0] cnt_gf;
        logic [35:0] cnt_auto;
        logic [7:0] imb_max;
        logic soft_clear;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t s_r; // Registered state.
    state_t s_nxt; // Next state.

    // ==========================================================
    // Functions.
    // ==========================================================
    // Advances a trip delay counter; any gap in the condition restarts it,
    // so only a persisting fault reaches the limit.
    function automatic logic [35:0] delay_step(input logic [35:0] cnt,
                                               input logic cond,
                                               input logic [35:0] lim);
        logic [35:0] r;
        r = '0;
        if (cond && cnt < lim)
        begin
            r = cnt + 36'h1;
        end
        else if (cond)
        begin
            r = cnt;
        end
        return r;
    endfunction

    // Percentage deviation of one phase from the average. Both sides are
    // scaled by three, so the average is never truncated.
    function automatic logic [7:0] imb_ratio(input logic [17:0] i3x,
                                             input logic [17:0] sum);
        logic [17:0] dev;
        logic [24:0] q;
        dev = (i3x > sum) ? i3x - sum : sum - i3x;
        q = '0;
        if (sum != 18'h0)
        begin
            q = (25'(dev) * 25'(PCT_SCALE)) / 25'(sum);
        end
        return (q > 25'hFF) ? 8'hFF : q[7:0];
    endfunction

    // Current below one tenth of the rated setting.
    function automatic logic is_low(input logic [15:0] i, input logic [15:0] ir);
        return (20'(i) * 20'(LOSS_LOW_DEN)) < 20'(ir);
    endfunction

    // Current above eight tenths of the rated setting.
    function automatic logic is_high(input logic [15:0] i, input logic [15:0] ir);
        return (20'(i) * 20'(LOSS_LOW_DEN)) > (20'(ir) * 20'(LOSS_HIGH_NUM));
    endfunction

    // ==========================================================
    // Fault detection.
    // ==========================================================
    logic [15:0] ir; // Synchronised rated current setting.
    logic [17:0] sum3; // Sum of the three phase currents.
    logic [7:0] r1, r2, r3; // Per-phase imbalance ratios.
    logic [7:0] r_max; // Network imbalance ratio.
    logic lo1, lo2, lo3, hi1, hi2, hi3; // Phase loss comparisons.
    logic loss_cond, imb_cond, gf_cond, therm_cond; // Live fault conditions.
    logic [3:0] req; // Trip requests after their delays.
    logic clear_req; // Button or register clear.
    logic auto_arm; // Automatic clearing is timing.

    assign ir = s_r.sync_b.rated_current_setting;
    assign sum3 = 18'(PHASE_CURRENTS_I.phase1_current) + 18'(PHASE_CURRENTS_I.phase2_current)
                  + 18'(PHASE_CURRENTS_I.phase3_current);
    assign r1 = imb_ratio(18'(PHASE_CURRENTS_I.phase1_current) * 18'h3, sum3);
    assign r2 = imb_ratio(18'(PHASE_CURRENTS_I.phase2_current) * 18'h3, sum3);
    assign r3 = imb_ratio(18'(PHASE_CURRENTS_I.phase3_current) * 18'h3, sum3);

    // Largest ratio wins.
    always_comb
    begin
        r_max = r1;
        if (r2 > r_max)
        begin
            r_max = r2;
        end
        if (r3 > r_max)
        begin
            r_max = r3;
        end
    end

    assign lo1 = is_low(PHASE_CURRENTS_I.phase1_current, ir);
    assign lo2 = is_low(PHASE_CURRENTS_I.phase2_current, ir);
    assign lo3 = is_low(PHASE_CURRENTS_I.phase3_current, ir);
    assign hi1 = is_high(PHASE_CURRENTS_I.phase1_current, ir);
    assign hi2 = is_high(PHASE_CURRENTS_I.phase2_current, ir);
    assign hi3 = is_high(PHASE_CURRENTS_I.phase3_current, ir);
    // No switch reaches this term, so phase loss is always watched.
    assign loss_cond = (lo1 & (hi2 | hi3)) | (lo2 & (hi1 | hi3)) | (lo3 & (hi1 | hi2));
    assign imb_cond = s_r.sync_b.imbalance_protect_enable && (r_max > IMB_LIMIT_PCT);
    // Ten percent of the 0.75 rated reference, as 75 parts per thousand.
    assign gf_cond = s_r.sync_b.ground_protect_enable
                     && (36'(GROUND_CURRENT_I) * 36'(GF_REF_DEN) > 36'(ir) * 36'(GF_REF_NUM));
    assign therm_cond = THERMAL_CAPACITY_I > THERMAL_LIMIT_PCT;

    // The thermal request fires at once; the others once a counter has seen its limit of unbroken cycles.
    always_comb
    begin
        req = '0;
        req[CAUSE_THERMAL] = therm_cond;
        req[CAUSE_PHASE_LOSS] = loss_cond && (s_r.cnt_loss == PHASE_LOSS_CYC_P);
        req[CAUSE_IMBALANCE] = imb_cond && (s_r.cnt_imb == IMBALANCE_CYC_P);
        req[CAUSE_GROUND] = gf_cond && (s_r.cnt_gf == GROUND_CYC_P);
    end

    assign clear_req = s_r.sync_b.reset_request || s_r.soft_clear;
    // Only a trip whose recorded cause is thermal alone may time out, and
    // only with the switch away from manual-only.
    assign auto_arm = s_r.trip && (s_r.cause == 4'h1) && !s_r.sync_b.manual_clear_setting;

    // ==========================================================
    // Next state.
    // ==========================================================
    // Trip latch, delay counters and the AXI4-Lite slave.
    always_comb
    begin
        logic aw_now;
        logic w_now;
        logic [7:0] ra;
        aw_now = 1'b0;
        w_now = 1'b0;
        ra = S_AXI_ARADDR_I;
        s_nxt = s_r;
        s_nxt.sync_a = SWITCHES_I;
        s_nxt.sync_b = s_r.sync_a;
        s_nxt.imb_max = r_max;
        s_nxt.soft_clear = 1'b0;
        s_nxt.cnt_loss = delay_step(s_r.cnt_loss, loss_cond, PHASE_LOSS_CYC_P);
        s_nxt.cnt_imb = delay_step(s_r.cnt_imb, imb_cond, IMBALANCE_CYC_P);
        s_nxt.cnt_gf = delay_step(s_r.cnt_gf, gf_cond, GROUND_CYC_P);
        s_nxt.cnt_auto = delay_step(s_r.cnt_auto, auto_arm, AUTO_CLEAR_CYC_P);
        // A new request always wins over a clear in the same cycle.
        if (req != 4'h0)
        begin
            s_nxt.trip = 1'b1;
            s_nxt.cause = s_r.cause | req;
        end
        else if (clear_req)
        begin
            // Manual clear works for every cause.
            s_nxt.trip = 1'b0;
            s_nxt.cause = '0;
        end
        else if (auto_arm && s_r.cnt_auto == AUTO_CLEAR_CYC_P)
        begin
            // Without auto_arm a thermal trip stays until a manual clear.
            s_nxt.trip = 1'b0;
            s_nxt.cause = '0;
        end
        s_nxt.nc_closed = !s_nxt.trip;
        // Write address and data are taken in either order.
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
        begin
            aw_now = 1'b1;
            s_nxt.awaddr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O)
        begin
            w_now = 1'b1;
            s_nxt.wdata = S_AXI_WDATA_I;
            s_nxt.wstrb = S_AXI_WSTRB_I;
        end
        s_nxt.aw_have = s_r.aw_have || aw_now;
        s_nxt.w_have = s_r.w_have || w_now;
        if (s_nxt.aw_have && s_nxt.w_have)
        begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            unique case (s_nxt.awaddr)
                REG_CTRL:
                begin
                    s_nxt.soft_clear = s_nxt.wstrb[0] && s_nxt.wdata[CTRL_CLEAR_BIT];
                end
                REG_STATUS, REG_IMBALANCE, REG_SETTINGS:
                begin
                    // Read-only registers ignore writes.
                    s_nxt.bresp = RESP_OKAY;
                end
                default:
                begin
                    s_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end
        else if (s_r.bvalid && S_AXI_BREADY_I)
        begin
            s_nxt.bvalid = 1'b0;
        end
        // Reads answer one cycle after the address is taken.
        if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rdata = '0;
            unique case (ra)
                REG_CTRL:
                begin
                    s_nxt.rdata = '0;
                end
                REG_STATUS:
                begin
                    s_nxt.rdata = {22'h0, therm_cond, gf_cond, imb_cond, loss_cond,
                                   s_r.cause, s_r.nc_closed, s_r.trip};
                end
                REG_IMBALANCE:
                begin
                    s_nxt.rdata = {24'h0, s_r.imb_max};
                end
                REG_SETTINGS:
                begin
                    s_nxt.rdata = {12'h0, s_r.sync_b};
                end
                default:
                begin
                    s_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (s_r.rvalid && S_AXI_RREADY_I)
        begin
            s_nxt.rvalid = 1'b0;
        end
    end

    // ==========================================================
    // Registers.
    // ==========================================================
    // Reset leaves the relay untripped with the NC contact closed.
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            s_r <= '0;
            s_r.nc_closed <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs.
    // ==========================================================
    // Handshake readies hold off while a response is still pending.
    assign S_AXI_AWREADY_O = !s_r.aw_have && !s_r.bvalid;
    assign S_AXI_WREADY_O = !s_r.w_have && !s_r.bvalid;
    assign S_AXI_ARREADY_O = !s_r.rvalid;
    assign S_AXI_BVALID_O = s_r.bvalid;
    assign S_AXI_BRESP_O = s_r.bresp;
    assign S_AXI_RVALID_O = s_r.rvalid;
    assign S_AXI_RDATA_O = s_r.rdata;
    assign S_AXI_RRESP_O = s_r.rresp;
    assign NC_CONTACT_CLOSED_O = s_r.nc_closed;
    assign NO_CONTACT_CLOSED_O = s_r.trip;
    assign TRIP_CAUSE_O = s_r.cause;
endmodule
`default_nettype wire

// ### bench/front_end_model.sv
// Behavioural front end: phase, ground and thermal values.
// Assumes the bench sets a stimulus code and a rated current of 100.
`timescale 1ns/100ps
`default_nettype none
module front_end_model
(
    // Clock, reset and stimulus code.
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [2:0] mode_i,
    // Values towards the trip logic.
    output trip_pkg::phase_currents_t cur_o,
    output logic [15:0] gnd_o,
    output logic [7:0] therm_o
);
    import trip_pkg::*;
    // Codes: 1 lost phase, 2 imbalance, 3 ground over, 4 thermal over,
    // 5 ground just under its limit; anything else is a healthy motor.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cur_o <= {3{16'h0064}};
            gnd_o <= 16'h0000;
            therm_o <= 8'h00;
        end
        else
        begin
            cur_o <= {3{16'h0064}};
            gnd_o <= (mode_i == 3'h3) ? 16'h0008 : ((mode_i == 3'h5) ? 16'h0007 : 16'h0000);
            therm_o <= (mode_i == 3'h4) ? 8'h65 : 8'h00;
            if (mode_i == 3'h1)
                cur_o <= {16'h0005, 16'h005A, 16'h005A};
            if (mode_i == 3'h2)
                cur_o <= {16'h0064, 16'h0064, 16'h0028};
        end
    end
endmodule
`default_nettype wire

// ### bench/motor_trip_asserts.sv
// Checker for the trip decision block, watching its top-level ports only.
// Assumes switch pins stay steady for a few cycles around every trip.
`timescale 1ns/100ps
`default_nettype none
module motor_trip_asserts
#(
    parameter logic [35:0] GROUND_CYC_P = 36'hA
)
(
    // Clock and reset.
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    // Register bus.
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    // Measurements, switches and contacts.
    input wire logic [15:0] GROUND_CURRENT_I,
    input wire logic [7:0] THERMAL_CAPACITY_I,
    input wire trip_pkg::switch_set_t SWITCHES_I,
    input wire logic NC_CONTACT_CLOSED_O,
    input wire logic NO_CONTACT_CLOSED_O,
    input wire logic [3:0] TRIP_CAUSE_O
);
    import trip_pkg::*;
    logic gnd_hit; // Ground current above its limit while enabled.
    logic [35:0] gnd_cnt; // Unbroken cycles of gnd_hit, saturating.
    // ==========================================================
    // Helper logic: a persistence counter for the ground condition.
    // ==========================================================
    assign gnd_hit = SWITCHES_I.ground_protect_enable &&
        (({10'h000, GROUND_CURRENT_I} * 26'h00003E8) > ({10'h000, SWITCHES_I.rated_current_setting} * 26'h000004B));
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            gnd_cnt <= '0;
        else if (!gnd_hit)
            gnd_cnt <= '0;
        else if (gnd_cnt < GROUND_CYC_P)
            gnd_cnt <= gnd_cnt + 36'h1;
    end
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    // Bus handshakes taken in full.
    sequence wr_taken;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    sequence rd_taken;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    endsequence
    contacts_opposite_a: assert property (NC_CONTACT_CLOSED_O != NO_CONTACT_CLOSED_O)
        else $error("contacts not opposite");
    thermal_trip_a: assert property (THERMAL_CAPACITY_I > THERMAL_LIMIT_PCT |-> ##[1:3] NO_CONTACT_CLOSED_O)
        else $error("thermal trip missing");
    latch_hold_a: assert property (NO_CONTACT_CLOSED_O && (SWITCHES_I.manual_clear_setting || TRIP_CAUSE_O != 4'h1)
        && !$past(S_AXI_WVALID_I) && !SWITCHES_I.reset_request && !$past(SWITCHES_I.reset_request)
        && !$past(SWITCHES_I.reset_request, 2) && !$past(SWITCHES_I.reset_request, 3) |=> NO_CONTACT_CLOSED_O)
        else $error("trip released without a clear");
    cause_recorded_a: assert property ($rose(NO_CONTACT_CLOSED_O) |-> TRIP_CAUSE_O != 4'h0)
        else $error("trip without cause");
    gnd_enable_a: assert property ($rose(TRIP_CAUSE_O[CAUSE_GROUND]) |-> $past(SWITCHES_I.ground_protect_enable, 3))
        else $error("ground trip while disabled");
    imb_enable_a: assert property ($rose(TRIP_CAUSE_O[CAUSE_IMBALANCE]) |-> $past(SWITCHES_I.imbalance_protect_enable, 3))
        else $error("imbalance trip while disabled");
    gnd_delay_a: assert property ($rose(TRIP_CAUSE_O[CAUSE_GROUND]) |-> gnd_cnt >= GROUND_CYC_P)
        else $error("ground trip too early");
    wr_answer_a: assert property (wr_taken |=> S_AXI_BVALID_O)
        else $error("write response missing");
    rd_answer_a: assert property (rd_taken |=> S_AXI_RVALID_O)
        else $error("read data missing");
    resp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped");
    unmapped_rd_a: assert property (rd_taken and S_AXI_ARADDR_I > REG_SETTINGS |=>
        S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind motor_trip motor_trip_asserts #(.GROUND_CYC_P(GROUND_CYC_P)) chk_u (.*);
`default_nettype wire

// ### bench/motor_trip_tb.sv
// Self-checking bench for the trip decision block with shortened delays.
// Assumes the front end model and a register-bus master in this file.
`timescale 1ns/100ps
`default_nettype none
module motor_trip_tb;
    import trip_pkg::*;
    logic mclk, arst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, nc, no;
    logic [7:0] awaddr, araddr, therm;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [15:0] gnd;
    logic [3:0] cause;
    logic [2:0] mode;
    phase_currents_t cur;
    switch_set_t sw;
    int errors = 0, check_count = 0, cyc = 0;
    front_end_model fe_u (.clk_i(mclk), .arst_n_i(arst_n), .mode_i(mode), .cur_o(cur), .gnd_o(gnd), .therm_o(therm));
    // Delays cut to 60, 20, 25 and 10 cycles so the run stays short.
    motor_trip #(.AUTO_CLEAR_CYC_P(36'h3C), .PHASE_LOSS_CYC_P(36'h14),
        .IMBALANCE_CYC_P(36'h19), .GROUND_CYC_P(36'hA)) dut_u (.MCLK_I(mclk), .ARST_N_I(arst_n),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .PHASE_CURRENTS_I(cur), .GROUND_CURRENT_I(gnd), .THERMAL_CAPACITY_I(therm),
        .SWITCHES_I(sw), .NC_CONTACT_CLOSED_O(nc), .NO_CONTACT_CLOSED_O(no), .TRIP_CAUSE_O(cause));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // A hung handshake is cut short here.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            test_done;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic clk_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Address and data go out together; each drops once taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge mclk); while (!bvalid);
        rs = bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
        v = rdata;
        rs = rresp;
    endtask
    // Applies a stimulus and expects the trip inside a window.
    task automatic trip_run(input logic [2:0] m, input int lo, input int hi);
        mode <= m;
        clk_n(lo);
        chk(no, 1'b0);
        clk_n(hi - lo);
        chk(no, 1'b1);
    endtask
    // Healthy currents, then a press of the reset button.
    task automatic clear_sw;
        mode <= 3'h0;
        clk_n(4);
        sw.reset_request <= 1'b1;
        clk_n(4);
        sw.reset_request <= 1'b0;
        clk_n(4);
        chk(no, 1'b0);
        chk(nc, 1'b1);
    endtask
    task automatic t_axi;
        axi_rd(REG_SETTINGS, d, r);
        chk(d, 32'h646);
        axi_rd(REG_STATUS, d, r);
        chk(d[1:0], 2'h2);
        axi_rd(REG_CTRL, d, r);
        chk(d, 32'h0);
        axi_wr(8'h10, 32'h1, r);
        chk(r, RESP_SLVERR);
        axi_rd(8'h10, d, r);
        chk(d, 32'h0);
        chk(r, RESP_SLVERR);
    endtask
    task automatic t_loss;
        sw.imbalance_protect_enable <= 1'b0;
        sw.ground_protect_enable <= 1'b0;
        clk_n(4);
        trip_run(3'h1, 18, 28);
        chk(cause, 4'h2);
        mode <= 3'h0;
        clk_n(100);
        chk(no, 1'b1);
        clear_sw;
        mode <= 3'h1;
        clk_n(14);
        mode <= 3'h0;
        clk_n(3);
        trip_run(3'h1, 18, 28);
        mode <= 3'h0;
        axi_wr(REG_CTRL, 32'h1, r);
        chk(r, RESP_OKAY);
        clk_n(4);
        chk(no, 1'b0);
    endtask
    task automatic t_imb;
        mode <= 3'h2;
        clk_n(60);
        chk(no, 1'b0);
        axi_rd(REG_IMBALANCE, d, r);
        chk(d, 32'h32);
        mode <= 3'h0;
        sw.imbalance_protect_enable <= 1'b1;
        clk_n(4);
        trip_run(3'h2, 23, 33);
        chk(cause, 4'h4);
        mode <= 3'h0;
        clk_n(100);
        chk(no, 1'b1);
        clear_sw;
    endtask
    task automatic t_gnd;
        mode <= 3'h3;
        clk_n(40);
        chk(no, 1'b0);
        mode <= 3'h0;
        sw.ground_protect_enable <= 1'b1;
        clk_n(4);
        mode <= 3'h5;
        clk_n(40);
        chk(no, 1'b0);
        trip_run(3'h3, 8, 18);
        chk(cause, 4'h8);
        mode <= 3'h0;
        clk_n(100);
        chk(no, 1'b1);
        clear_sw;
    endtask
    task automatic t_therm;
        trip_run(3'h4, 1, 6);
        chk(cause, 4'h1);
        sw.reset_request <= 1'b1;
        clk_n(6);
        chk(no, 1'b1);
        sw.reset_request <= 1'b0;
        clk_n(4);
        mode <= 3'h0;
        clk_n(40);
        chk(no, 1'b1);
        clk_n(45);
        chk(no, 1'b0);
        sw.manual_clear_setting <= 1'b1;
        clk_n(4);
        trip_run(3'h4, 1, 6);
        mode <= 3'h0;
        clk_n(100);
        chk(no, 1'b1);
        axi_wr(REG_CTRL, 32'h1, r);
        clk_n(4);
        chk(no, 1'b0);
    endtask
    task test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        arst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = '0;
        mode = 3'h0;
        sw = {16'h0064, 4'h6};
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        clk_n(4);
        t_axi;
        t_loss;
        t_imb;
        t_gnd;
        t_therm;
        test_done;
    end
endmodule
`default_nettype wire
